// *** rtl/otp_lock_consts.svh ***
`ifndef OTP_LOCK_CONSTS_SVH
`define OTP_LOCK_CONSTS_SVH

`define ENC_DEPTH        64
`define ENC_SEL_BITS     6
`define ENC_ERASED       8'hff
`define ADDR_BITS        14
`define REG_CTRL         32'h0000_0000
`define REG_STATUS       32'h0000_0004
`define REG_CODE_ADDR    32'h0000_0008
`define REG_CODE_DATA    32'h0000_000c
`define REG_ENC_ADDR     32'h0000_0010
`define REG_SIG_BASE     32'h0000_0020
`define CTRL_MODE_LSB    0
`define CTRL_START_BIT   4
`define CTRL_VOE_BIT     5
`define CTRL_VPP_BIT     6
`define CTRL_LOCK_LSB    8
`define AXI_OKAY         2'h0
`define AXI_SLVERR       2'h2
`define PROG_PULSE_NS    100
`define CLK_PERIOD_NS    40
`define PROG_PULSE_CYC   ((`PROG_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** rtl/otp_lock_pkg.sv ***
package otp_lock_pkg;
    typedef enum logic [2:0]
    {
        MODE_IDLE   = 3'b000,
        MODE_PROG   = 3'b001,
        MODE_VERIFY = 3'b010,
        MODE_SIG    = 3'b011,
        MODE_LOCK   = 3'b100,
        MODE_ENC    = 3'b101
    } prog_mode_t;

    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'b00,
        ST_PULSE = 2'b01,
        ST_DONE  = 2'b10
    } prog_state_t;

    typedef enum logic [1:0]
    {
        LEVEL_1 = 2'b00,
        LEVEL_2 = 2'b01,
        LEVEL_3 = 2'b10,
        LEVEL_4 = 2'b11
    } sec_level_t;
endpackage

// *** rtl/enc_xnor.sv ***
`timescale 1ns/1ns
`include "otp_lock_consts.svh"
module enc_xnor
    import otp_lock_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    input  wire logic [WIDTH-1:0] code_i,
    input  wire logic [WIDTH-1:0] key_i,
    output wire logic [WIDTH-1:0] crypt_o
);
    genvar b;
    generate
        for (b = 0; b < WIDTH; b++)
        begin : g_bit
            assign crypt_o[b] = ~(code_i[b] ^ key_i[b]);
        end
    endgenerate
endmodule

// *** rtl/otp_lock_core.sv ***
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "otp_lock_consts.svh"
// Overview of operation
// - 64 encryption bytes, erased to all ones
// - six address lines pick encryption byte
// - verify byte is code XNOR key
// - three one-time lock bits, four levels
// - level 1: no locks, external reads plain
// - level 2: block reads, latch strap, no programming except lock bits
// - level 3: level 2 plus verify disabled
// - level 4: level 3 plus no external execution
// - four read-only signature bytes readable
// - one programming pulse commits a byte
// - data driven only while verify enable high
// - verify returns encrypted code byte
// - no direct encryption array read path
module otp_lock_core
    import otp_lock_pkg::*;
#(
    parameter int         ADDR_W = `ADDR_BITS,
    parameter logic [7:0] SIG0   = 8'h5a,  // arbitrary value
    parameter logic [7:0] SIG1   = 8'ha5,  // arbitrary value
    parameter logic [7:0] SIG2   = 8'h3c,  // arbitrary value
    parameter logic [7:0] SIG3   = 8'hc3   // arbitrary value
)
(
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    input  wire logic              clk_en_i,
    input  wire logic [31:0]       s_axi_awaddr_i,
    input  wire logic              s_axi_awvalid_i,
    output wire logic              s_axi_awready_o,
    input  wire logic [31:0]       s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    input  wire logic              s_axi_wvalid_i,
    output wire logic              s_axi_wready_o,
    output wire logic [1:0]        s_axi_bresp_o,
    output wire logic              s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    input  wire logic [31:0]       s_axi_araddr_i,
    input  wire logic              s_axi_arvalid_i,
    output wire logic              s_axi_arready_o,
    output wire logic [31:0]       s_axi_rdata_o,
    output wire logic [1:0]        s_axi_rresp_o,
    output wire logic              s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i,
    input  wire logic              external_access_pin_i,
    input  wire logic              table_read_req_i,
    input  wire logic              table_read_from_ext_i,
    input  wire logic [ADDR_W-1:0] table_read_addr_i,
    output wire logic [7:0]        table_read_data_o,
    output wire logic              table_read_ok_o,
    output wire logic              ext_access_latched_o,
    output wire logic              ext_exec_allow_o,
    output wire logic              prog_pulse_o,
    output wire logic [7:0]        verify_data_o,
    output wire logic              verify_data_oe_o
);
    localparam int DEPTH = 1 << ADDR_W;
    localparam int PCYC  = (`PROG_PULSE_CYC < 1) ? 1 : `PROG_PULSE_CYC;

    // cells start erased; reset never touches them
    logic [7:0]        code_mem [DEPTH] = '{default: `ENC_ERASED};
    logic [7:0]        enc_mem  [`ENC_DEPTH] = '{default: `ENC_ERASED};
    // one-time lock cells survive reset, so the strap latch can see them
    logic [2:0]        lock_q = 3'b000;
    logic [2:0]        mode_q;
    logic              voe_q;
    logic              vpp_q;
    logic [ADDR_W-1:0] addr_q;
    logic [7:0]        wbyte_q;
    logic [5:0]        encsel_q;
    prog_state_t       st_q;
    logic [7:0]        cnt_q;
    logic              refused_q;
    logic              strap_q;
    logic              strap_taken_q;
    logic [7:0]        vdata_q;
    logic [7:0]        trd_q;
    logic              trok_q;
    logic              aw_q, w_q, b_q, r_q;
    logic [31:0]       awaddr_q, wdata_q, rdata_q;
    logic [1:0]        bresp_q, rresp_q;

    // level decode: highest-numbered programmed bit that raises the level wins
    wire lock_bit_one   = lock_q[0];
    wire lock_bit_two   = lock_q[1];
    wire lock_bit_three = lock_q[2];
    wire lvl4 = lock_bit_three;
    wire lvl3 = lock_bit_two | lvl4;
    wire lvl2 = lock_bit_one | lvl3;
    wire [1:0] level = lvl4 ? LEVEL_4 : lvl3 ? LEVEL_3 : lvl2 ? LEVEL_2 : LEVEL_1;

    wire [5:0] enc_idx   = addr_q[`ENC_SEL_BITS-1:0];
    wire [7:0] code_byte = code_mem[addr_q];
    wire [7:0] crypt;
    enc_xnor #(.WIDTH(8)) u_xnor
    (
        .code_i  (code_byte),
        .key_i   (enc_mem[enc_idx]),
        .crypt_o (crypt)
    );

    wire [7:0] sig_byte = (addr_q[1:0] == 2'd0) ? SIG0 :
                          (addr_q[1:0] == 2'd1) ? SIG1 :
                          (addr_q[1:0] == 2'd2) ? SIG2 : SIG3;
    wire verify_mode = (mode_q == MODE_VERIFY);
    wire verify_en   = verify_mode & ~lvl3;
    wire [7:0] vnext = verify_en ? crypt : (mode_q == MODE_SIG) ? sig_byte : 8'h00;
    wire prog_mode   = (mode_q == MODE_PROG) | (mode_q == MODE_ENC) | (mode_q == MODE_LOCK);
    wire prog_ok     = ~lvl2 | (mode_q == MODE_LOCK);

    // table read: from external memory only when level 1
    wire tr_allow = ~table_read_from_ext_i | ~lvl2;

    wire aw_hs = s_axi_awvalid_i & ~aw_q;
    wire w_hs  = s_axi_wvalid_i & ~w_q;
    wire aw_have = aw_q | aw_hs;
    wire w_have  = w_q | w_hs;
    wire [31:0] waddr = aw_q ? awaddr_q : s_axi_awaddr_i;
    wire [31:0] wdat  = w_q ? wdata_q : s_axi_wdata_i;
    wire do_write = aw_have & w_have & ~b_q;
    wire wr_ctrl  = do_write & (waddr == `REG_CTRL) & s_axi_wstrb_i[0];
    wire wr_ok    = (waddr == `REG_CTRL) | (waddr == `REG_CODE_ADDR) |
                    (waddr == `REG_CODE_DATA) | (waddr == `REG_ENC_ADDR);
    wire start    = wr_ctrl & wdat[`CTRL_START_BIT];
    wire ar_hs    = s_axi_arvalid_i & ~r_q;
    wire [31:0] rd_mux =
        (s_axi_araddr_i == `REG_CTRL)      ? {21'h0, lock_q, 1'b0, vpp_q, voe_q,
                                              1'b0, 1'b0, mode_q} :
        (s_axi_araddr_i == `REG_STATUS)    ? {24'h0, refused_q, strap_q, st_q, level, 2'h0} :
        (s_axi_araddr_i == `REG_CODE_ADDR) ? {{(32-ADDR_W){1'b0}}, addr_q} :
        (s_axi_araddr_i == `REG_CODE_DATA) ? {24'h0, voe_q ? vdata_q : 8'h00} :
        (s_axi_araddr_i == `REG_ENC_ADDR)  ? {26'h0, encsel_q} : 32'h0;
    wire rd_ok = (s_axi_araddr_i <= `REG_ENC_ADDR) & (s_axi_araddr_i[1:0] == 2'b00);

    assign s_axi_awready_o = ~aw_q;
    assign s_axi_wready_o  = ~w_q;
    assign s_axi_bvalid_o  = b_q;
    assign s_axi_bresp_o   = bresp_q;
    assign s_axi_arready_o = ~r_q;
    assign s_axi_rvalid_o  = r_q;
    assign s_axi_rdata_o   = rdata_q;
    assign s_axi_rresp_o   = rresp_q;
    assign table_read_data_o    = trd_q;
    assign table_read_ok_o      = trok_q;
    assign ext_access_latched_o = strap_q;
    assign ext_exec_allow_o     = ~lvl4 & ~strap_q;
    assign prog_pulse_o         = (st_q == ST_PULSE);
    assign verify_data_o        = vdata_q;
    assign verify_data_oe_o     = voe_q & (verify_en | (mode_q == MODE_SIG));

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            aw_q <= 1'b0; w_q <= 1'b0; b_q <= 1'b0; r_q <= 1'b0;
            awaddr_q <= 32'h0; wdata_q <= 32'h0; rdata_q <= 32'h0;
            bresp_q <= `AXI_OKAY; rresp_q <= `AXI_OKAY;
        end
        else if (clk_en_i)
        begin
            if (do_write)
            begin
                aw_q <= 1'b0; w_q <= 1'b0; b_q <= 1'b1;
                bresp_q <= wr_ok ? `AXI_OKAY : `AXI_SLVERR;
            end
            else
            begin
                if (aw_hs) begin aw_q <= 1'b1; awaddr_q <= s_axi_awaddr_i; end
                if (w_hs) begin w_q <= 1'b1; wdata_q <= s_axi_wdata_i; end
                if (b_q & s_axi_bready_i) b_q <= 1'b0;
            end
            if (ar_hs)
            begin
                r_q <= 1'b1;
                rdata_q <= rd_mux;
                rresp_q <= rd_ok ? `AXI_OKAY : `AXI_SLVERR;
            end
            else if (r_q & s_axi_rready_i) r_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            mode_q <= MODE_IDLE; voe_q <= 1'b0; vpp_q <= 1'b0;
            addr_q <= '0; wbyte_q <= 8'h00; encsel_q <= 6'h00;
        end
        else if (clk_en_i & do_write)
        begin
            if (wr_ctrl)
            begin
                mode_q <= wdat[`CTRL_MODE_LSB +: 3];
                voe_q  <= wdat[`CTRL_VOE_BIT];
                vpp_q  <= wdat[`CTRL_VPP_BIT];
            end
            if (waddr == `REG_CODE_ADDR) addr_q <= wdat[ADDR_W-1:0];
            if (waddr == `REG_CODE_DATA) wbyte_q <= wdat[7:0];
            if (waddr == `REG_ENC_ADDR) encsel_q <= wdat[5:0];
        end
    end

    // single pulse commits the byte; lock bits only ever go from 0 to 1
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            st_q <= ST_IDLE; cnt_q <= 8'h00; refused_q <= 1'b0;
        end
        else if (clk_en_i)
        begin
            case (st_q)
                ST_IDLE:
                    if (start & prog_mode)
                    begin
                        if (prog_ok & vpp_q)
                        begin
                            st_q <= ST_PULSE;
                            cnt_q <= 8'(PCYC - 1);
                            refused_q <= 1'b0;
                        end
                        else refused_q <= 1'b1;
                    end
                ST_PULSE:
                    if (cnt_q == 8'h00)
                    begin
                        st_q <= ST_DONE;
                        if (mode_q == MODE_LOCK) lock_q <= lock_q | wbyte_q[2:0];
                    end
                    else cnt_q <= cnt_q - 8'h01;
                ST_DONE: st_q <= ST_IDLE;
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // programming only clears bits, as in a real one-time cell
    always_ff @(posedge sys_clk_i)
    begin
        if (clk_en_i & ~rst_i & (st_q == ST_PULSE) & (cnt_q == 8'h00))
        begin
            if (mode_q == MODE_PROG) code_mem[addr_q] <= code_mem[addr_q] & wbyte_q;
            if (mode_q == MODE_ENC) enc_mem[encsel_q] <= enc_mem[encsel_q] & wbyte_q;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            strap_taken_q <= 1'b0; strap_q <= 1'b0; vdata_q <= 8'h00;
            trd_q <= 8'h00; trok_q <= 1'b0;
        end
        else if (clk_en_i)
        begin
            // strap caught on the first edge after release
            if (~strap_taken_q)
            begin
                strap_taken_q <= 1'b1;
                strap_q <= lvl2 & ~external_access_pin_i;
            end
            vdata_q <= vnext;
            trok_q  <= table_read_req_i & tr_allow;
            trd_q   <= (table_read_req_i & tr_allow) ? code_mem[table_read_addr_i] : 8'h00;
        end
    end

    property p_verify_lock;
        @(posedge sys_clk_i) disable iff (rst_i) lvl3 |-> !verify_data_oe_o || mode_q == MODE_SIG;
    endproperty
    a_verify_lock: assert property (p_verify_lock) else $error("verify out under lock");
    property p_prog_refuse;
        @(posedge sys_clk_i) disable iff (rst_i)
            clk_en_i && st_q == ST_IDLE && start && mode_q == MODE_PROG && lvl2
            |=> st_q == ST_IDLE && refused_q;
    endproperty
    a_prog_refuse: assert property (p_prog_refuse) else $error("program not refused");
    property p_ext_block;
        @(posedge sys_clk_i) disable iff (rst_i)
            clk_en_i && table_read_req_i && table_read_from_ext_i && lvl2 |=> !trok_q;
    endproperty
    a_ext_block: assert property (p_ext_block) else $error("external table read leaked");
    property p_ext_exec;
        @(posedge sys_clk_i) disable iff (rst_i) lvl4 |-> !ext_exec_allow_o;
    endproperty
    a_ext_exec: assert property (p_ext_exec) else $error("external execution under lock");
    property p_xnor;
        @(posedge sys_clk_i) disable iff (rst_i)
            clk_en_i && verify_en |=> vdata_q == ~($past(code_byte) ^ $past(enc_mem[enc_idx]));
    endproperty
    a_xnor: assert property (p_xnor) else $error("verify byte not xnor");
    sequence s_pulse;
        st_q == ST_PULSE [*1];
    endsequence
    property p_one_pulse;
        @(posedge sys_clk_i) disable iff (rst_i)
            $rose(prog_pulse_o) |-> prog_pulse_o [*3] ##1 !prog_pulse_o;
    endproperty
    a_one_pulse: assert property (p_one_pulse) else $error("extra program pulse");
    property p_pulse_done;
        @(posedge sys_clk_i) disable iff (rst_i)
            s_pulse ##0 (clk_en_i && cnt_q == 8'h00) |=> st_q == ST_DONE;
    endproperty
    a_pulse_done: assert property (p_pulse_done) else $error("pulse did not end");
    property p_oe;
        @(posedge sys_clk_i) disable iff (rst_i) !voe_q |-> !verify_data_oe_o;
    endproperty
    a_oe: assert property (p_oe) else $error("data driven without enable");
    property p_lock_sticky;
        @(posedge sys_clk_i) disable iff (rst_i) ($past(lock_q) & ~lock_q) == 3'b000;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit erased");
endmodule

// *** sim/prog_station.sv ***
`timescale 1ns/1ns
`include "otp_lock_consts.svh"
module prog_station
    import otp_lock_pkg::*;
(
    input  wire logic        clk_i,
    output logic      [31:0] awaddr_o,
    output logic             awvalid_o,
    input  wire logic        awready_i,
    output logic      [31:0] wdata_o,
    output logic      [3:0]  wstrb_o,
    output logic             wvalid_o,
    input  wire logic        wready_i,
    input  wire logic [1:0]  bresp_i,
    input  wire logic        bvalid_i,
    output logic             bready_o,
    output logic      [31:0] araddr_o,
    output logic             arvalid_o,
    input  wire logic        arready_i,
    input  wire logic [31:0] rdata_i,
    input  wire logic [1:0]  rresp_i,
    input  wire logic        rvalid_i,
    output logic             rready_o
);
    logic hung = 1'b0;
    initial
    begin
        {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o} = '0;
        {bready_o, araddr_o, arvalid_o, rready_o} = '0;
    end
    task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk_i);
        awaddr_o <= a;
        wdata_o <= d;
        wstrb_o <= 4'hf;
        awvalid_o <= 1'b1;
        wvalid_o <= 1'b1;
        bready_o <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk_i);
            // released lines must not keep showing the old value
            if (awvalid_o && awready_i)
            begin
                awvalid_o <= 1'b0;
                awaddr_o <= ~a;
            end
            if (wvalid_o && wready_i)
            begin
                wvalid_o <= 1'b0;
                wdata_o <= ~d;
            end
            if (bvalid_i)
            begin
                r = bresp_i;
                bready_o <= 1'b0;
                break;
            end
        end
        if (n == 50)
            hung = 1'b1;
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk_i);
        araddr_o <= a;
        arvalid_o <= 1'b1;
        rready_o <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk_i);
            if (arvalid_o && arready_i)
            begin
                arvalid_o <= 1'b0;
                araddr_o <= ~a;
            end
            if (rvalid_i)
            begin
                d = rdata_i;
                r = rresp_i;
                rready_o <= 1'b0;
                break;
            end
        end
        if (n == 50)
            hung = 1'b1;
    endtask
    // one byte: address, data, mode with vpp raised, single pulse, lower vpp
    task automatic program_byte(input logic [2:0] m, input logic [13:0] a, input logic [7:0] d);
        logic [31:0] st;
        logic [1:0]  r;
        int          n;
        wr(`REG_CODE_ADDR, {18'h0, a}, r);
        wr(`REG_ENC_ADDR, {26'h0, a[5:0]}, r);
        wr(`REG_CODE_DATA, {24'h0, d}, r);
        wr(`REG_CTRL, {25'h0, 1'b1, 3'h0, m}, r);
        wr(`REG_CTRL, {25'h0, 1'b1, 1'b0, 1'b1, 1'b0, m}, r);
        for (n = 0; n < 20; n++)
        begin
            rd(`REG_STATUS, st, r);
            if (st[5:4] == 2'h0)
                break;
        end
        if (n == 20)
            hung = 1'b1;
        wr(`REG_CTRL, 32'h0, r);
    endtask
    task automatic probe(input logic [2:0] m, input logic oe, input logic [13:0] a,
                         output logic [31:0] d);
        logic [1:0] r;
        wr(`REG_CTRL, {26'h0, oe, 2'h0, m}, r);
        wr(`REG_CODE_ADDR, {18'h0, a}, r);
        rd(`REG_CODE_DATA, d, r);
    endtask
endmodule

// *** sim/tb_otp_lock_core.sv ***
`timescale 1ns/1ns
`include "otp_lock_consts.svh"
module tb_otp_lock_core
    import otp_lock_pkg::*;
;
    logic        sys_clk_i;
    logic        rst_i;
    logic        clk_en_i;
    logic        external_access_pin_i;
    logic        table_read_req_i;
    logic        table_read_from_ext_i;
    logic [13:0] table_read_addr_i;
    wire  [7:0]  table_read_data_o;
    wire         table_read_ok_o;
    wire         ext_exec_allow_o;
    wire         prog_pulse_o;
    wire         verify_data_oe_o;
    wire         ext_access_latched_o;
    wire  [7:0]  verify_data_o;
    wire  [31:0] awaddr, wdata, araddr, rdata;
    wire  [3:0]  wstrb;
    wire  [1:0]  bresp, rresp;
    wire         awvalid, awready, wvalid, wready, bvalid, bready;
    wire         arvalid, arready, rvalid, rready;
    int          err_count = 0;
    int          n_checks = 0;
    int          pulse_n = 0;
    int          cyc = 0;
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  td;
    logic        tok;
    logic [7:0]  sig [4] = '{8'h21, 8'h42, 8'h63, 8'h84}; // arbitrary values

    otp_lock_core #(.SIG0(8'h21), .SIG1(8'h42), .SIG2(8'h63), .SIG3(8'h84)) u_dut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .external_access_pin_i(external_access_pin_i), .table_read_req_i(table_read_req_i),
        .table_read_from_ext_i(table_read_from_ext_i), .table_read_addr_i(table_read_addr_i),
        .table_read_data_o(table_read_data_o), .table_read_ok_o(table_read_ok_o),
        .ext_access_latched_o(ext_access_latched_o), .ext_exec_allow_o(ext_exec_allow_o),
        .prog_pulse_o(prog_pulse_o), .verify_data_o(verify_data_o),
        .verify_data_oe_o(verify_data_oe_o));

    prog_station u_prog (
        .clk_i(sys_clk_i), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
        .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid), .wready_i(wready),
        .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr),
        .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp),
        .rvalid_i(rvalid), .rready_o(rready));

    initial
    begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i)
    begin
        cyc++;
        if (prog_pulse_o === 1'b1)
            pulse_n++;
        if (u_prog.hung || cyc > 60000)
        begin
            err_count++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic do_reset;
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        rst_i <= 1'b0;
    endtask
    // request taken at one edge, answer stands in the following cycle
    task automatic tread(input logic ext, input logic [13:0] a);
        @(posedge sys_clk_i);
        table_read_req_i <= 1'b1;
        table_read_from_ext_i <= ext;
        table_read_addr_i <= a;
        @(posedge sys_clk_i);
        table_read_req_i <= 1'b0;
        #1;
        td = table_read_data_o;
        tok = table_read_ok_o;
    endtask

    initial
    begin
        rst_i = 1'b1;
        clk_en_i = 1'b1;
        // strap high: external code allowed, so only level 4 stops it
        external_access_pin_i = 1'b1;
        table_read_req_i = 1'b0;
        table_read_from_ext_i = 1'b0;
        table_read_addr_i = 14'h0;
        do_reset();
        u_prog.rd(`REG_CTRL, d, r);
        chk(d, 32'h0);
        u_prog.rd(`REG_STATUS, d, r);
        chk(d, 32'h0);
        u_prog.rd(32'h40, d, r);
        chk(d, 32'h0);
        chk({30'h0, r}, {30'h0, `AXI_SLVERR});
        u_prog.wr(32'h44, 32'h1, r);
        chk({30'h0, r}, {30'h0, `AXI_SLVERR});
        $display("test reset done");
        u_prog.probe(MODE_VERIFY, 1'b1, 14'h0123, d);
        chk(d, 32'h0000_00ff);
        pulse_n = 0;
        u_prog.program_byte(MODE_PROG, 14'h0045, 8'h3c);
        chk(pulse_n, `PROG_PULSE_CYC);
        u_prog.rd(`REG_STATUS, d, r);
        chk({31'h0, d[7]}, 32'h0);
        u_prog.probe(MODE_VERIFY, 1'b1, 14'h0045, d);
        chk(d, 32'h0000_003c);
        u_prog.program_byte(MODE_ENC, 14'h0005, 8'ha5);
        u_prog.probe(MODE_VERIFY, 1'b1, 14'h0045, d);
        chk(d, 32'h0000_0066);
        chk({24'h0, verify_data_o}, 32'h0000_0066);
        u_prog.probe(MODE_VERIFY, 1'b1, 14'h0005, d);
        chk(d, 32'h0000_00a5);
        u_prog.probe(MODE_VERIFY, 1'b1, 14'h2fc5, d);
        chk(d, 32'h0000_00a5);
        u_prog.probe(MODE_VERIFY, 1'b1, 14'h0006, d);
        chk(d, 32'h0000_00ff);
        chk({31'h0, verify_data_oe_o}, 32'h1);
        u_prog.probe(MODE_VERIFY, 1'b0, 14'h0045, d);
        chk(d, 32'h0);
        chk({31'h0, verify_data_oe_o}, 32'h0);
        $display("test program verify done");
        tread(1'b1, 14'h0045);
        chk({23'h0, tok, td}, {23'h0, 1'b1, 8'h3c});
        chk({31'h0, ext_exec_allow_o}, 32'h1);
        for (int i = 0; i < 4; i++)
        begin
            u_prog.probe(MODE_SIG, 1'b1, 14'(i), d);
            chk(d, {24'h0, sig[i]});
        end
        $display("test level one done");
        // frozen: a table read must not reach the output register
        clk_en_i <= 1'b0;
        tread(1'b1, 14'h0045);
        chk({23'h0, tok, td}, 32'h0);
        clk_en_i <= 1'b1;
        $display("test clock enable done");
        for (int k = 0; k < 3; k++)
        begin
            do_reset();
            u_prog.program_byte(MODE_LOCK, 14'h0, 8'(1 << k));
            u_prog.rd(`REG_CTRL, d, r);
            chk({29'h0, d[10:8]}, 32'((2 << k) - 1));
            u_prog.rd(`REG_STATUS, d, r);
            chk({30'h0, d[3:2]}, 32'(k + 1));
            tread(1'b1, 14'h0045);
            chk({23'h0, tok, td}, 32'h0);
            tread(1'b0, 14'h0045);
            chk({23'h0, tok, td}, {23'h0, 1'b1, 8'h3c});
            pulse_n = 0;
            u_prog.program_byte(MODE_PROG, 14'h0047, 8'h00);
            u_prog.rd(`REG_STATUS, d, r);
            chk({d[7], 31'(pulse_n)}, {1'b1, 31'h0});
            u_prog.probe(MODE_VERIFY, 1'b1, 14'h0045, d);
            chk(d, (k == 0) ? 32'h0000_0066 : 32'h0);
            chk({30'h0, ext_access_latched_o, ext_exec_allow_o}, (k == 2) ? 32'h0 : 32'h1);
            $display("test lock level %0d done", k + 2);
        end
        // strap low across a reset while locked: latched until the next reset
        external_access_pin_i <= 1'b0;
        do_reset();
        u_prog.rd(`REG_STATUS, d, r);
        chk({30'h0, d[6], ext_access_latched_o}, 32'h3);
        $display("test strap latch done");
        wrap_up();
    end
endmodule
